// File: hdl/frx_rom_ctrl.sv
// Controller that addresses and strobes the kanji pattern ROM array.
//
// What this block does
// - 24x24: eight locations per chip, nine chips
// - 24x24: character set split over two nine-chip halves
// - 16x18: four locations, ten chips, skip unused
// - Compressed code: twelve bits; non-kanji codes carry two zeros inside
// - Non-kanji: Y7Y6, X3..X1, 00, Y5..Y1
// - 24-bit row: pins from a11..a1, b3..b1
// - 24x24 group from top code bit, row 5:4
// - 16-bit row: pins from all code, row 2:1
// - 16x18 group decode from row bits 5:3
`timescale 1ns/1ps
`default_nettype none
module frx_rom_ctrl
    import frx_pkg::*;
(
    input  wire logic                     core_clk,     // 40 MHz clock.
    input  wire logic                     rst_n,        // Async reset, low.
    // Request side from the character display controller.
    input  wire logic                     req_valid,    // Row read request.
    output logic                          req_ready,    // Request taken.
    input  wire logic                     req_font,     // 0 wide, 1 narrow.
    input  wire logic                     req_nonkanji, // Use source fields.
    input  wire logic [CODE_W-1:0]        req_code,     // Compressed code.
    input  wire logic [SRC_ROW_W-1:0]     req_src_row,  // Non-kanji row field.
    input  wire logic [SRC_COL_W-1:0]     req_src_col,  // Non-kanji col field.
    input  wire logic [ROW_W-1:0]         req_row,      // Row index, 5 bits.
    output logic                          rsp_valid,    // Row data pulse.
    output logic [WIDE_PER_GRP*DATA_W-1:0] rsp_dots,    // Row of dots.
    output logic                          rsp_miss,     // No group selected.
    // Pattern ROM array pins.
    output logic [ADDR_W-1:0]             rom_addr,     // Shared address.
    output logic [WIDE_CHIPS-1:0]         rom_ce_n,     // Chip enables.
    output logic [WIDE_CHIPS-1:0]         rom_oe_n,     // Output gates.
    input  wire logic [WIDE_CHIPS*DATA_W-1:0] rom_data  // All chip outputs.
);

    // ==================================================================
    // Decoding helpers
    // ==================================================================
    // One-hot 24x24 group from top code bit, row bits 5:4; 011, 111 miss.
    function automatic logic [WIDE_GROUPS-1:0] wide_group(
        input logic [2:0] sel
    );
        logic [WIDE_GROUPS-1:0] g;
        g = '0;
        case (sel)
            3'h0:    g = 6'h01;
            3'h1:    g = 6'h02;
            3'h2:    g = 6'h04;
            3'h4:    g = 6'h08;
            3'h5:    g = 6'h10;
            3'h6:    g = 6'h20;
            default: g = '0;
        endcase
        return g;
    endfunction

    // One-hot 16x18 group from row bits 5:3; values above 100 pick nothing.
    function automatic logic [NARROW_GROUPS-1:0] narrow_group(
        input logic [2:0] sel
    );
        logic [NARROW_GROUPS-1:0] g;
        g = '0;
        case (sel)
            3'h0:    g = 5'h01;
            3'h1:    g = 5'h02;
            3'h2:    g = 5'h04;
            3'h3:    g = 5'h08;
            3'h4:    g = 5'h10;
            default: g = '0;
        endcase
        return g;
    endfunction

    // ==================================================================
    // Held request
    // ==================================================================
    frx_state_t             state;      // Read sequencer state.
    frx_state_t             next_state; // Next sequencer state.
    logic [CNT_W-1:0]       wait_cnt;   // Cycles left of ROM access.
    logic                   font;       // Held font select.
    logic [CODE_W-1:0]      code;       // Held compressed code.
    logic [ROW_W-1:0]       row;        // Held row index.
    logic [CODE_W-1:0]      nk_code;    // Compressed non-kanji code.
    logic [CODE_W-1:0]      in_code;    // Code chosen at the request.
    logic                   take;       // Request accepted this cycle.

    // The non-kanji fields are packed by the small compression module.
    frx_code_compress u_compress (
        .src_row   (req_src_row),
        .src_col   (req_src_col),
        .comp_code (nk_code)
    );

    assign in_code   = req_nonkanji ? nk_code : req_code;
    assign req_ready = (state == FRX_IDLE);
    assign take      = req_valid && req_ready;

    // ==================================================================
    // Address and strobe decode
    // ==================================================================
    logic [ADDR_W-1:0]        addr_wide;   // 24-bit row address.
    logic [ADDR_W-1:0]        addr_narrow; // 16-bit row address.
    logic [WIDE_GROUPS-1:0]   grp_wide;    // 24x24 group one-hot.
    logic [NARROW_GROUPS-1:0] grp_narrow;  // 16x18 group one-hot.
    logic [WIDE_CHIPS-1:0]    chip_sel;    // Active chips, high true.
    logic                     active;      // Strobes may be asserted.

    // Code bit a(n) sits at index n-1; row bit b(n) at index n-1.
    // The top code bit is dropped; it picks the upper or lower nine chips.
    assign addr_wide   = {code[10:0], row[2:0]};
    // Each 16x18 chip sees four locations per character.
    assign addr_narrow = {code[11:0], row[1:0]};
    assign grp_wide    = wide_group({code[11], row[4:3]});
    assign grp_narrow  = narrow_group(row[4:2]);

    // Expand groups to chips; narrow groups reuse the first ten chips.
    always_comb begin
        chip_sel = '0;
        for (int g = 0; g < WIDE_GROUPS; g++) begin
            if (font == FONT_WIDE && grp_wide[g]) begin
                chip_sel[g*WIDE_PER_GRP +: WIDE_PER_GRP] = '1;
            end
        end
        for (int g = 0; g < NARROW_GROUPS; g++) begin
            if (font == FONT_NARROW && grp_narrow[g]) begin
                chip_sel[g*NARROW_PER_GRP +: NARROW_PER_GRP] = '1;
            end
        end
    end

    assign active = (state == FRX_WAIT);

    // ==================================================================
    // Row assembly
    // ==================================================================
    // Only gated chips drive, so an OR over the selected ones yields the
    // row; foreground dots read as one and pass through unchanged.
    logic [WIDE_PER_GRP*DATA_W-1:0] row_dots; // Assembled dot row.
    always_comb begin
        row_dots = '0;
        for (int c = 0; c < WIDE_CHIPS; c++) begin
            if (chip_sel[c]) begin
                if (font == FONT_WIDE) begin
                    row_dots[(c%WIDE_PER_GRP)*DATA_W +: DATA_W] =
                        row_dots[(c%WIDE_PER_GRP)*DATA_W +: DATA_W]
                        | rom_data[c*DATA_W +: DATA_W];
                end else begin
                    row_dots[(c%NARROW_PER_GRP)*DATA_W +: DATA_W] =
                        row_dots[(c%NARROW_PER_GRP)*DATA_W +: DATA_W]
                        | rom_data[c*DATA_W +: DATA_W];
                end
            end
        end
    end

    // ==================================================================
    // Sequencer
    // ==================================================================
    // Next state: wait out the ROM access, then present the row once.
    always_comb begin
        case (state)
            FRX_IDLE: next_state = take ? FRX_WAIT : FRX_IDLE;
            FRX_WAIT: next_state = (wait_cnt == '0) ? FRX_DONE : FRX_WAIT;
            FRX_DONE: next_state = FRX_IDLE;
            default:  next_state = FRX_IDLE;
        endcase
    end

    // State, access counter and held request.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= FRX_IDLE;
            wait_cnt <= '0;
            font     <= FONT_WIDE;
            code     <= '0;
            row      <= '0;
        end else begin
            state <= next_state;
            if (take) begin
                // Pins change one edge after the take, so the whole access
                // count is waited from there before the row is sampled.
                wait_cnt <= CNT_W'(ACCESS_CYC);
                font     <= req_font;
                code     <= in_code;
                row      <= req_row;
            end else if (wait_cnt != '0) begin
                wait_cnt <= wait_cnt - 1'b1;
            end
        end
    end

    // Pin drivers: strobes low for the selected group only.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_addr <= '0;
            rom_ce_n <= '1;
            rom_oe_n <= '1;
        end else begin
            rom_addr <= (font == FONT_WIDE) ? addr_wide : addr_narrow;
            rom_ce_n <= ~(chip_sel & {WIDE_CHIPS{active}});
            rom_oe_n <= ~(chip_sel & {WIDE_CHIPS{active}});
        end
    end

    // Response capture on the last access cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_dots  <= '0;
            rsp_miss  <= 1'b0;
        end else begin
            rsp_valid <= (state == FRX_WAIT) && (wait_cnt == '0);
            if ((state == FRX_WAIT) && (wait_cnt == '0)) begin
                rsp_dots <= row_dots;
                rsp_miss <= (chip_sel == '0);
            end
        end
    end

endmodule
`default_nettype wire

// File: shared/frx_pkg.sv
// Shared constants for the font ROM array addressing controller.
package frx_pkg;

    // ==================================================================
    // Code and address widths
    // ==================================================================
    localparam int CODE_W    = 12;   // Compressed character code, 12 bits.
    localparam int ROW_W     = 5;    // Row index within a character, 5 bits.
    localparam int ADDR_W    = 14;   // Pattern ROM address pins 13..0.
    localparam int DATA_W    = 8;    // Pattern ROM data width.
    localparam int SRC_ROW_W = 7;    // Non-kanji source row field Y7..Y1.
    localparam int SRC_COL_W = 3;    // Non-kanji source column field X3..X1.

    // ==================================================================
    // Array layout
    // ==================================================================
    localparam int WIDE_GROUPS   = 6;  // Three-chip groups, 24x24 font.
    localparam int WIDE_PER_GRP  = 3;  // Chips per group in 24x24 font.
    localparam int WIDE_CHIPS    = 18; // All chips of the 24x24 font.
    localparam int WIDE_LOCS     = 8;  // Locations per chip per character.
    localparam int NARROW_GROUPS = 5;  // Two-chip groups, 16x18 font.
    localparam int NARROW_PER_GRP= 2;  // Chips per group in 16x18 font.
    localparam int NARROW_LOCS   = 4;  // Locations per chip per character.
    localparam int NARROW_ROWS   = 18; // Useful rows in a 16x18 character.
    localparam int WIDE_ROWS     = 24; // Useful rows in a 24x24 character.

    // ==================================================================
    // Timing
    // ==================================================================
    localparam int CLK_PERIOD_NS = 25;   // Clock period at 40 MHz.
    localparam int ROM_ACCESS_NS = 450;  // Pattern ROM access time, longest.
    // Least wait, rounded up to whole cycles.
    localparam int ACCESS_CYC    =
        (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 5;    // Wide enough for ACCESS_CYC.

    // ==================================================================
    // Font select
    // ==================================================================
    localparam logic FONT_WIDE   = 1'b0; // 24x24 font, 24-bit rows.
    localparam logic FONT_NARROW = 1'b1; // 16x18 font, 16-bit rows.

    // Read sequencer states, Gray coded along idle -> wait -> done.
    typedef enum logic [1:0] {
        FRX_IDLE = 2'b00,
        FRX_WAIT = 2'b01,
        FRX_DONE = 2'b11
    } frx_state_t;

endpackage

// File: hdl/frx_code_compress.sv
// Non-kanji code compression from source row and column fields.
`timescale 1ns/1ps
`default_nettype none
module frx_code_compress
    import frx_pkg::*;
(
    input  wire logic [SRC_ROW_W-1:0] src_row,  // Source row field Y7..Y1.
    input  wire logic [SRC_COL_W-1:0] src_col,  // Source column field X3..X1.
    output logic      [CODE_W-1:0]    comp_code // Compressed twelve-bit code.
);
    // ==================================================================
    // Field placement
    // ==================================================================
    // Index 11 is the top code bit; Y7,Y6 on top, X3..X1, 00, Y5..Y1.
    assign comp_code = {src_row[6:5], src_col, 2'b00, src_row[4:0]};
endmodule
`default_nettype wire

// File: testbench/frx_rom_ctrl_assertions.sv
// Port checker for the font ROM array controller, bound to its top.
`timescale 1ns/1ps
`default_nettype none
module frx_rom_ctrl_chk
    import frx_pkg::*;
(
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic                     req_valid,
    input wire logic                     req_ready,
    input wire logic                     req_font,
    input wire logic                     req_nonkanji,
    input wire logic [CODE_W-1:0]        req_code,
    input wire logic [SRC_ROW_W-1:0]     req_src_row,
    input wire logic [SRC_COL_W-1:0]     req_src_col,
    input wire logic [ROW_W-1:0]         req_row,
    input wire logic                     rsp_valid,
    input wire logic [WIDE_PER_GRP*DATA_W-1:0] rsp_dots,
    input wire logic                     rsp_miss,
    input wire logic [ADDR_W-1:0]        rom_addr,
    input wire logic [WIDE_CHIPS-1:0]    rom_ce_n,
    input wire logic [WIDE_CHIPS-1:0]    rom_oe_n
);
    // ==================================================================
    // Helper decode
    // ==================================================================
    wire logic take;  // A request is accepted at this edge.
    assign take = req_valid && req_ready;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ==================================================================
    // Assertions
    // ==================================================================
    a_answer_time: assert property (take |-> ##20 rsp_valid)
        else $error("Row answer not on time.");
    a_busy_quiet: assert property (take |=> (!req_ready && !rsp_valid) [*8])
        else $error("Early answer or ready while busy.");
    a_strobe_pair: assert property (rom_ce_n == rom_oe_n)
        else $error("Chip enable and output gate differ.");
    a_one_group: assert property ($countones(~rom_ce_n) inside {0, 2, 3})
        else $error("Strobes low on a wrong number of chips.");
    a_idle_dark: assert property (req_ready |-> &rom_oe_n)
        else $error("Strobes low while idle.");
    a_wide_addr: assert property (take && !req_font && !req_nonkanji |-> ##2
        rom_addr == {$past(req_code[10:0], 2), $past(req_row[2:0], 2)})
        else $error("Wide row address wrong.");
    a_narrow_addr: assert property (take && req_font && !req_nonkanji |-> ##2
        rom_addr == {$past(req_code, 2), $past(req_row[1:0], 2)})
        else $error("Narrow row address wrong.");
    a_symbol_code: assert property (take && !req_font && req_nonkanji |-> ##2
        rom_addr[13:3] == {$past(req_src_row[5:5], 2), $past(req_src_col, 2),
        2'b00, $past(req_src_row[4:0], 2)})
        else $error("Symbol code address wrong.");
    a_wide_miss: assert property (take && !req_font && req_row[4:3] == 2'b11
        |-> ##20 rsp_miss && rsp_dots == 24'h000000)
        else $error("Wide unused group not a miss.");
    a_narrow_miss: assert property (take && req_font && req_row[4:2] > 3'h4
        |-> ##20 rsp_miss && rsp_dots == 24'h000000)
        else $error("Narrow unused group not a miss.");
endmodule

bind frx_rom_ctrl frx_rom_ctrl_chk i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_font(req_font), .req_nonkanji(req_nonkanji),
    .req_code(req_code), .req_src_row(req_src_row),
    .req_src_col(req_src_col), .req_row(req_row), .rsp_valid(rsp_valid),
    .rsp_dots(rsp_dots), .rsp_miss(rsp_miss), .rom_addr(rom_addr),
    .rom_ce_n(rom_ce_n), .rom_oe_n(rom_oe_n)
);
`default_nettype wire

// File: testbench/frx_rom_model.sv
// Behavioural pattern ROM array: eighteen byte-wide asynchronous chips.
`timescale 1ns/1ps
`default_nettype none
module frx_rom_model
    import frx_pkg::*;
(
    input  wire logic [ADDR_W-1:0]            rom_addr,  // Shared address.
    input  wire logic [WIDE_CHIPS-1:0]        rom_ce_n,  // Chip enables.
    input  wire logic [WIDE_CHIPS-1:0]        rom_oe_n,  // Output gates.
    output logic      [WIDE_CHIPS*DATA_W-1:0] rom_data   // All chip outputs.
);
    // ==================================================================
    // Chip contents
    // ==================================================================
    // Each byte mixes address and chip number, so a wrong chip or a
    // wrong address pin shows up as a wrong row of dots.
    always_comb begin
        for (int c = 0; c < WIDE_CHIPS; c++) begin
            if (!rom_ce_n[c] && !rom_oe_n[c]) begin
                rom_data[8*c +: 8] = rom_addr[7:0] ^ rom_addr[13:6]
                    ^ 8'(c * 29);
            end else begin
                // A released chip floats; it is shown as all ones so that a
                // controller gathering an unselected chip sees stray dots.
                rom_data[8*c +: 8] = 8'hff;
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_frx_rom_ctrl.sv
// Self-checking bench for the font ROM array controller.
`timescale 1ns/1ps
`default_nettype none
module tb_frx_rom_ctrl
    import frx_pkg::*;
;
    logic        core_clk = 0, rst_n = 0, req_valid = 0, req_ready;
    logic        req_font = 0, req_nonkanji = 0, rsp_valid, rsp_miss;
    logic [11:0] req_code = 0;
    logic [6:0]  req_src_row = 0;
    logic [2:0]  req_src_col = 0;
    logic [4:0]  req_row = 0;
    logic [23:0] rsp_dots;
    logic [13:0] rom_addr;
    logic [17:0] rom_ce_n, rom_oe_n;
    logic [143:0] rom_data;
    int          err_count = 0, compares = 0, cycles = 0;

    frx_rom_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req_font(req_font),
        .req_nonkanji(req_nonkanji), .req_code(req_code),
        .req_src_row(req_src_row), .req_src_col(req_src_col),
        .req_row(req_row), .rsp_valid(rsp_valid), .rsp_dots(rsp_dots),
        .rsp_miss(rsp_miss), .rom_addr(rom_addr), .rom_ce_n(rom_ce_n),
        .rom_oe_n(rom_oe_n), .rom_data(rom_data));
    frx_rom_model i_rom (.rom_addr(rom_addr), .rom_ce_n(rom_ce_n),
        .rom_oe_n(rom_oe_n), .rom_data(rom_data));

    // ==================================================================
    // Clock, timeout and verdict
    // ==================================================================
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // Each request takes 21 cycles; the ceiling leaves ample room.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp_dots(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t dots %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t flag %h exp %h", $time, got, exp);
        end
    endtask

    // ==================================================================
    // Reference model: returns the miss flag above the row of dots
    // ==================================================================
    function automatic logic [24:0] model(logic font, logic nk,
        logic [11:0] code, logic [6:0] sr, logic [2:0] sc, logic [4:0] row);
        int a, g, n;
        logic [23:0] d;
        if (nk) code = {sr[6:5], sc, 2'b00, sr[4:0]};
        n = font ? 2 : 3;
        a = font ? int'({code, row[1:0]}) : int'({code[10:0], row[2:0]});
        g = font ? int'(row[4:2]) : int'({code[11], row[4:3]});
        if (font) g = (g > 4) ? -1 : g;
        else g = (g == 3 || g == 7) ? -1 : ((g > 3) ? g - 1 : g);
        d = 24'h000000;
        for (int j = 0; j < n && g >= 0; j++) begin
            d[8*j +: 8] = 8'((a ^ (a >> 6) ^ ((g * n + j) * 29)) & 255);
        end
        return {g < 0, d};
    endfunction

    // ==================================================================
    // One row read, held busy for a refusal, then checked
    // ==================================================================
    task automatic run_one(input int i);
        logic [24:0] e;
        logic [11:0] code;
        logic [4:0]  row;
        logic        font, nk;
        logic [6:0]  sr;
        logic [2:0]  sc;
        code = 12'($urandom);
        row = 5'($urandom);
        sr = 7'($urandom);
        sc = 3'($urandom);
        font = (i < 16) ? i[3] : 1'($urandom);
        nk = (i < 16) ? 1'b0 : 1'($urandom);
        // The first sixteen walk every group value of both fonts.
        if (i < 16 && !font) {code[11], row[4:3]} = i[2:0];
        else if (i < 16) row[4:2] = i[2:0];
        else row = font ? row % 18 : row % 24;
        e = model(font, nk, code, sr, sc, row);
        @(posedge core_clk);
        req_valid <= 1'b1;
        {req_font, req_nonkanji, req_code} <= {font, nk, code};
        {req_src_row, req_src_col, req_row} <= {sr, sc, row};
        do @(posedge core_clk); while (req_ready !== 1'b1);
        // Held valid with other fields: a busy block must ignore it.
        req_code <= ~code;
        req_row <= ~row;
        // The answer stands for the one cycle after the nineteenth edge.
        for (int k = 1; k <= 19; k++) begin
            @(posedge core_clk);
            if (k == 2) req_valid <= 1'b0;
        end
        #1;
        cmp_flag(rsp_valid, 1'b1);
        cmp_flag(rsp_miss, e[24]);
        cmp_dots(rsp_dots, e[23:0]);
    endtask

    initial begin
        void'($urandom(32'hbdf7));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 56; i++) run_one(i);
        conclude();
    end
endmodule
`default_nettype wire
